// ---- logic/ssr_core.sv ----
// serial peripheral status, flag and data register logic with shift engine
//
// How it works
// - transfer done sets bit 7, may interrupt
// - done clears after status access, data access
// - data writes ignored while done, until status read
// - data write during transfer sets collision bit 6
// - byte arriving while done sets overrun bit 5
// - status read clears overrun
// - select low as master sets fault bit 4
// - fault clears: control access then control write
// - output disable releases serial output pin
// - soft select ignores pin, uses internal bit
// - internal bit zero selects, one deselects
// - master data write starts one byte transfer
// - last cycle copies shift byte to read buffer only while done is clear
// - permitted write loads shift register directly
// - data, control, status at three consecutive addresses
// - reset clears whole status register
// - shared interrupt from done, fault, overrun
// - collision flag never causes interrupt
// - mode fault clears enable and master bits
`include "ssr_regs.svh"
`timescale 1ns/1ns
`default_nettype none
module ssr_core
    import ssr_pkg::*;
(
    // clock, reset, enable
    input  wire logic       core_clk_i,
    input  wire logic       reset_i,
    input  wire logic       clk_en_i,
    // register port
    input  wire logic [7:0] addr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    output logic      [7:0] rdata_o,
    output logic            irq_o,
    // serial clock pin
    input  wire logic       sck_i,
    output logic            sck_o,
    output logic            sck_oe_o,
    // master out slave in pin
    input  wire logic       mosi_i,
    output logic            mosi_o,
    output logic            mosi_oe_o,
    // master in slave out pin
    input  wire logic       miso_i,
    output logic            miso_o,
    output logic            miso_oe_o,
    // slave select pin
    input  wire logic       ss_n_i
);

    ssr_bus_req_t bus;
    ssr_pins_t    pin_meta_reg;
    ssr_pins_t    pin_sync_reg;
    logic         sck_prev_reg;
    logic [7:0] ctrl_reg;
    logic       xfer_done_flag_reg;
    logic       write_collision_flag_reg;
    logic       overrun_flag_reg;
    logic       mode_fault_flag_reg;
    logic       output_disable_reg;
    logic       select_soft_manage_reg;
    logic       internal_select_level_reg;
    logic       csr_seen_reg;
    logic       csr_read_seen_reg;
    logic       ctrl_seen_reg;
    ssr_state_t state_reg;
    logic [7:0] shift_reg;
    logic [7:0] rx_buf_reg;
    logic [3:0] bit_cnt_reg;
    logic [6:0] div_cnt_reg;
    logic       sck_int_reg;
    logic       sampled_reg;
    logic       out_bit_reg;
    // register bus decode
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction
    assign bus = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};
    logic acc_data;
    logic acc_ctrl;
    logic acc_csr;
    assign acc_data = (bus.wr | bus.rd) & hit(bus.addr, `SSR_OFF_DATA);
    assign acc_ctrl = (bus.wr | bus.rd) & hit(bus.addr, `SSR_OFF_CTRL);
    assign acc_csr  = (bus.wr | bus.rd) & hit(bus.addr, `SSR_OFF_CSR);

    // pin synchroniser
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            pin_meta_reg <= '{sck: 1'b0, mosi: 1'b0, miso: 1'b0, ss_n: 1'b1};
            pin_sync_reg <= '{sck: 1'b0, mosi: 1'b0, miso: 1'b0, ss_n: 1'b1};
            sck_prev_reg <= 1'b0;
        end else if (clk_en_i) begin
            pin_meta_reg <= '{sck: sck_i, mosi: mosi_i, miso: miso_i, ss_n: ss_n_i};
            pin_sync_reg <= pin_meta_reg;
            sck_prev_reg <= pin_sync_reg.sck;
        end
    end

    logic periph_en;
    logic is_master;
    logic cpol;
    logic cpha;
    logic select_n;
    assign periph_en = ctrl_reg[`SSR_CTRL_PERIPH_EN];
    assign is_master = ctrl_reg[`SSR_CTRL_MASTER];
    assign cpol      = ctrl_reg[`SSR_CTRL_CPOL];
    assign cpha      = ctrl_reg[`SSR_CTRL_CPHA];
    assign select_n  = select_soft_manage_reg ? internal_select_level_reg : pin_sync_reg.ss_n;

    logic fault_evt;
    assign fault_evt = periph_en & is_master & ~select_n;

    // transfer engine events
    logic busy;
    logic data_wr_ok;
    logic byte_done;
    logic lead_edge;
    logic trail_edge;
    logic slave_lead;
    logic slave_trail;
    logic half_tick;
    logic [6:0] half_period;

    assign busy = (state_reg == SSR_SHIFT);
    assign data_wr_ok = bus.wr & hit(bus.addr, `SSR_OFF_DATA) & ~busy & ~(xfer_done_flag_reg & ~csr_read_seen_reg);

    // master half period from divider and rate select bits
    always_comb begin
        case ({ctrl_reg[`SSR_CTRL_DIV_EN], ctrl_reg[1:0]})
            3'b100:  half_period = `SSR_HALF_4;
            3'b000:  half_period = `SSR_HALF_8;
            3'b001:  half_period = `SSR_HALF_16;
            3'b110:  half_period = `SSR_HALF_32;
            3'b010:  half_period = `SSR_HALF_64;
            3'b011:  half_period = `SSR_HALF_128;
            default: half_period = `SSR_HALF_8;
        endcase
    end

    assign half_tick   = is_master & busy & (div_cnt_reg == half_period);
    assign slave_lead  = ~is_master & ~select_n & (pin_sync_reg.sck != sck_prev_reg) & (pin_sync_reg.sck != cpol);
    assign slave_trail = ~is_master & ~select_n & (pin_sync_reg.sck != sck_prev_reg) & (pin_sync_reg.sck == cpol);
    assign lead_edge   = is_master ? (half_tick & (sck_int_reg == cpol)) : slave_lead;
    assign trail_edge  = is_master ? (half_tick & (sck_int_reg != cpol)) : slave_trail;
    assign byte_done   = busy & trail_edge & (bit_cnt_reg == `SSR_BITS_PER_BYTE - 4'h1);

    logic in_bit;
    assign in_bit = is_master ? pin_sync_reg.miso : pin_sync_reg.mosi;

    // shift engine
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            state_reg   <= SSR_IDLE;
            shift_reg   <= 8'h00;
            bit_cnt_reg <= 4'h0;
            div_cnt_reg <= 7'h00;
            sck_int_reg <= 1'b0;
            sampled_reg <= 1'b0;
            out_bit_reg <= 1'b0;
        end else if (clk_en_i) begin
            case (state_reg)
                SSR_IDLE: begin
                    sck_int_reg <= cpol;
                    div_cnt_reg <= 7'h00;
                    bit_cnt_reg <= 4'h0;
                    if (data_wr_ok) begin
                        shift_reg   <= bus.wdata;
                        out_bit_reg <= bus.wdata[7];
                        if (is_master & periph_en) begin
                            state_reg <= SSR_SHIFT;
                        end
                    end
                    if (periph_en & ~is_master & ~select_n & (slave_lead | slave_trail)) begin
                        state_reg <= SSR_SHIFT;
                        if (cpha ? slave_lead : 1'b0) begin
                            out_bit_reg <= shift_reg[7];
                        end else if (slave_lead) begin
                            sampled_reg <= in_bit;
                        end
                    end
                end
                SSR_SHIFT: begin
                    if (~periph_en) begin
                        state_reg <= SSR_IDLE;
                    end else begin
                        if (is_master) begin
                            div_cnt_reg <= half_tick ? 7'h00 : div_cnt_reg + 7'h01;
                            if (half_tick) begin
                                sck_int_reg <= ~sck_int_reg;
                            end
                        end
                        // sample on the capture edge, shift on the trailing edge in both phase modes
                        if (cpha ? trail_edge : lead_edge) begin
                            sampled_reg <= in_bit;
                        end
                        if (trail_edge) begin
                            shift_reg   <= {shift_reg[6:0], cpha ? in_bit : sampled_reg};
                            out_bit_reg <= shift_reg[6];
                            bit_cnt_reg <= bit_cnt_reg + 4'h1;
                        end
                        if (byte_done) begin
                            state_reg <= SSR_DONE;
                        end
                    end
                end
                SSR_DONE: begin
                    sck_int_reg <= cpol;
                    state_reg   <= SSR_IDLE;
                end
                default: state_reg <= SSR_IDLE;
            endcase
        end
    end

    logic [7:0] rx_byte;
    assign rx_byte = {shift_reg[6:0], cpha ? in_bit : sampled_reg};

    // read buffer
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            rx_buf_reg <= 8'h00;
        end else if (clk_en_i) begin
            if (byte_done & ~xfer_done_flag_reg) begin
                rx_buf_reg <= rx_byte;
            end
        end
    end

    // control register
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            ctrl_reg <= `SSR_CTRL_RESET;
        end else if (clk_en_i) begin
            if (bus.wr & hit(bus.addr, `SSR_OFF_CTRL)) begin
                ctrl_reg <= bus.wdata;
            end
            if (fault_evt) begin
                ctrl_reg[`SSR_CTRL_PERIPH_EN] <= 1'b0;
                ctrl_reg[`SSR_CTRL_MASTER]    <= 1'b0;
            end
        end
    end

    // sequence trackers for the clearing sequences
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            csr_seen_reg      <= 1'b0;
            csr_read_seen_reg <= 1'b0;
            ctrl_seen_reg     <= 1'b0;
        end else if (clk_en_i) begin
            if (acc_csr) begin
                csr_seen_reg <= 1'b1;
            end else if (acc_data) begin
                csr_seen_reg <= 1'b0;
            end
            if (bus.rd & hit(bus.addr, `SSR_OFF_CSR)) begin
                csr_read_seen_reg <= 1'b1;
            end else if (acc_data) begin
                csr_read_seen_reg <= 1'b0;
            end
            if (acc_ctrl & mode_fault_flag_reg) begin
                ctrl_seen_reg <= 1'b1;
            end else if (~mode_fault_flag_reg) begin
                ctrl_seen_reg <= 1'b0;
            end
        end
    end

    // status flags: a set in the same cycle as its clear wins
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            xfer_done_flag_reg       <= 1'b0;
            write_collision_flag_reg <= 1'b0;
            overrun_flag_reg         <= 1'b0;
            mode_fault_flag_reg      <= 1'b0;
        end else if (clk_en_i) begin
            if (byte_done) begin
                xfer_done_flag_reg <= 1'b1;
            end else if (acc_data & csr_seen_reg) begin
                xfer_done_flag_reg <= 1'b0;
            end
            if (bus.wr & hit(bus.addr, `SSR_OFF_DATA) & busy) begin
                write_collision_flag_reg <= 1'b1;
            end else if (acc_data & csr_read_seen_reg) begin
                write_collision_flag_reg <= 1'b0;
            end
            if (byte_done & xfer_done_flag_reg) begin
                overrun_flag_reg <= 1'b1;
            end else if (bus.rd & hit(bus.addr, `SSR_OFF_CSR)) begin
                overrun_flag_reg <= 1'b0;
            end
            if (fault_evt) begin
                mode_fault_flag_reg <= 1'b1;
            end else if (bus.wr & hit(bus.addr, `SSR_OFF_CTRL) & ctrl_seen_reg) begin
                mode_fault_flag_reg <= 1'b0;
            end
        end
    end

    // software control bits of the status register
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            output_disable_reg        <= 1'b0;
            select_soft_manage_reg    <= 1'b0;
            internal_select_level_reg <= 1'b0;
        end else if (clk_en_i) begin
            if (bus.wr & hit(bus.addr, `SSR_OFF_CSR)) begin
                output_disable_reg        <= bus.wdata[`SSR_CSR_OUT_DIS];
                select_soft_manage_reg    <= bus.wdata[`SSR_CSR_SOFT_SEL];
                internal_select_level_reg <= bus.wdata[`SSR_CSR_INT_SEL];
            end
        end
    end

    // read data, one cycle after the strobe
    logic [7:0] csr_value;
    assign csr_value = {xfer_done_flag_reg, write_collision_flag_reg, overrun_flag_reg, mode_fault_flag_reg,
                        1'b0, output_disable_reg, select_soft_manage_reg, internal_select_level_reg};

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            rdata_o <= 8'h00;
        end else if (clk_en_i) begin
            if (bus.rd) begin
                if (hit(bus.addr, `SSR_OFF_DATA)) begin
                    rdata_o <= rx_buf_reg;
                end else if (hit(bus.addr, `SSR_OFF_CTRL)) begin
                    rdata_o <= ctrl_reg;
                end else if (hit(bus.addr, `SSR_OFF_CSR)) begin
                    rdata_o <= csr_value;
                end else begin
                    rdata_o <= 8'h00;
                end
            end else begin
                rdata_o <= 8'h00;
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            irq_o <= 1'b0;
        end else if (clk_en_i) begin
            irq_o <= ctrl_reg[`SSR_CTRL_IRQ_EN] & (xfer_done_flag_reg | mode_fault_flag_reg | overrun_flag_reg);
        end
    end

    // pin drivers
    logic out_allowed;
    assign out_allowed = periph_en & ~output_disable_reg;

    assign sck_o     = sck_int_reg;
    assign sck_oe_o  = periph_en & is_master;
    assign mosi_o    = out_bit_reg;
    assign mosi_oe_o = out_allowed & is_master;
    assign miso_o    = out_bit_reg;
    assign miso_oe_o = out_allowed & ~is_master & ~select_n;

endmodule
`default_nettype wire

// ---- logic/ssr_pkg.sv ----
// types shared by the serial status/data block
`default_nettype none
package ssr_pkg;
    typedef enum logic [1:0] {
        SSR_IDLE,
        SSR_SHIFT,
        SSR_DONE
    } ssr_state_t;

    // register bus request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } ssr_bus_req_t;

    // serial pins seen from the block
    typedef struct packed {
        logic sck;
        logic mosi;
        logic miso;
        logic ss_n;
    } ssr_pins_t;
endpackage
`default_nettype wire

// ---- logic/ssr_regs.svh ----
// register offsets, bit positions, reset values and timing counts of the serial status/data block
`ifndef SSR_REGS_SVH
`define SSR_REGS_SVH
`define SSR_ADDR_W          8
`define SSR_OFF_DATA        8'h21
`define SSR_OFF_CTRL        8'h22
`define SSR_OFF_CSR         8'h23
`define SSR_CTRL_IRQ_EN     7
`define SSR_CTRL_PERIPH_EN  6
`define SSR_CTRL_DIV_EN     5
`define SSR_CTRL_MASTER     4
`define SSR_CTRL_CPOL       3
`define SSR_CTRL_CPHA       2
`define SSR_CSR_XFER_DONE   7
`define SSR_CSR_WRITE_COLLISION_FLAG        6
`define SSR_CSR_OVERRUN     5
`define SSR_CSR_MODE_FAULT  4
`define SSR_CSR_RSVD        3
`define SSR_CSR_OUT_DIS     2
`define SSR_CSR_SOFT_SEL    1
`define SSR_CSR_INT_SEL     0
`define SSR_CTRL_RESET      8'h00
`define SSR_CSR_RESET       8'h00
`define SSR_BITS_PER_BYTE   4'h8
`define SSR_HALF_4          7'h01
`define SSR_HALF_8          7'h03
`define SSR_HALF_16         7'h07
`define SSR_HALF_32         7'h0F
`define SSR_HALF_64         7'h1F
`define SSR_HALF_128        7'h3F
`endif

// ---- sim/ssr_core_chk.sv ----
// port assertions for the serial status/data block
`include "ssr_regs.svh"
`timescale 1ns/1ns
`default_nettype none
module ssr_core_chk (
    // clock and register port
    input wire logic       core_clk_i,
    input wire logic       reset_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic       wr_i,
    input wire logic       rd_i,
    input wire logic [7:0] rdata_o,
    input wire logic       irq_o,
    // pins
    input wire logic       sck_oe_o,
    input wire logic       mosi_oe_o,
    input wire logic       miso_oe_o,
    input wire logic       ss_n_i
);
    logic ien_q;
    logic [2:0] sel_q;
    // shadows of written enables
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            ien_q <= 1'b0;
        end else if (wr_i && addr_i == `SSR_OFF_CTRL) begin
            ien_q <= wdata_i[`SSR_CTRL_IRQ_EN];
        end
    end
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            sel_q <= 3'h0;
        end else if (wr_i && addr_i == `SSR_OFF_CSR) begin
            sel_q <= wdata_i[2:0];
        end
    end
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (reset_i);
    AST_RDATA_ZERO: assert property (!$past(rd_i) || !($past(addr_i) inside {8'h21, 8'h22, 8'h23})
        |-> rdata_o == 8'h00) else $error("rdata not zero");
    AST_RSVD_ZERO: assert property ($past(rd_i && addr_i == `SSR_OFF_CSR) |-> !rdata_o[3])
        else $error("reserved bit set");
    AST_IRQ_FLAGS: assert property ($past(rd_i && addr_i == `SSR_OFF_CSR)
        |-> irq_o == ($past(ien_q) && (rdata_o[7] || rdata_o[5] || rdata_o[4]))) else $error("irq mismatch");
    AST_MOSI_OE: assert property (mosi_oe_o == (sck_oe_o && !sel_q[2])) else $error("mosi enable");
    AST_MISO_OE: assert property (miso_oe_o |-> !sck_oe_o && !sel_q[2]) else $error("miso enable");
    AST_MODE_FAULT: assert property ($fell(ss_n_i) && sck_oe_o && !sel_q[1]
        |-> ##[1:8] !sck_oe_o && !mosi_oe_o) else $error("no fault stop");
    AST_SOFT_SEL: assert property (sel_q[1] && sel_q[0] && sck_oe_o && !wr_i |=> sck_oe_o)
        else $error("pin not ignored");
    AST_RESET_QUIET: assert property ($fell(reset_i) |-> !irq_o && rdata_o == 8'h00
        && !sck_oe_o && !mosi_oe_o && !miso_oe_o) else $error("not quiet after reset");
    COV_IRQ: cover property ($rose(irq_o));
    COV_STOP: cover property ($fell(sck_oe_o));
    COV_SLAVE: cover property ($rose(miso_oe_o));
endmodule
bind ssr_core ssr_core_chk u_chk (.core_clk_i(core_clk_i), .reset_i(reset_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o), .sck_oe_o(sck_oe_o),
    .mosi_oe_o(mosi_oe_o), .miso_oe_o(miso_oe_o), .ss_n_i(ss_n_i));
`default_nettype wire

// ---- sim/ssr_core_tb_top.sv ----
// testbench for the serial status/data block
`include "ssr_regs.svh"
`timescale 1ns/1ns
`default_nettype none
module ssr_core_tb_top;
    logic       core_clk_i, reset_i, wr_i, rd_i, ss_n_i, far_load, far_go, far_sck, far_sdo;
    logic       irq_o, sck_o, sck_oe_o, mosi_o, mosi_oe_o, miso_o, miso_oe_o, sck_w, mosi_w, miso_w;
    logic [7:0] addr_i, wdata_i, rdata_o, far_tx, far_rx;
    int         far_frames, n_fail, tests_run;
    assign sck_w = sck_oe_o ? sck_o : far_sck;
    assign mosi_w = mosi_oe_o ? mosi_o : far_sdo;
    assign miso_w = miso_oe_o ? miso_o : far_sdo;
    ssr_core dut (.core_clk_i(core_clk_i), .reset_i(reset_i), .clk_en_i(1'b1), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o), .sck_i(sck_w),
        .sck_o(sck_o), .sck_oe_o(sck_oe_o), .mosi_i(mosi_w), .mosi_o(mosi_o), .mosi_oe_o(mosi_oe_o),
        .miso_i(miso_w), .miso_o(miso_o), .miso_oe_o(miso_oe_o), .ss_n_i(ss_n_i));
    ssr_far_end far (.sck_in(sck_w), .sdi(sck_oe_o ? mosi_w : miso_w), .tx(far_tx), .load(far_load),
        .go(far_go), .sck(far_sck), .sdo(far_sdo), .rx(far_rx), .frames(far_frames));
    initial begin
        core_clk_i = 1'b0;
        forever #5 core_clk_i = ~core_clk_i;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] e);
        tests_run++;
        if (got !== e) begin
            n_fail++;
            $display("ERROR %0t got %h expected %h", $time, got, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge core_clk_i);
        wr_i <= 1'b0;
        @(posedge core_clk_i);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge core_clk_i);
        rd_i <= 1'b0;
        #1;
        chk(rdata_o, e);
        @(posedge core_clk_i);
    endtask
    // bit 1 slave output enable, bit 0 interrupt
    task automatic pins_chk(input logic [1:0] e);
        @(negedge core_clk_i);
        chk({6'h00, miso_oe_o, irq_o}, {6'h00, e});
        @(posedge core_clk_i);
    endtask
    task automatic prep(input logic [7:0] v);
        far_tx <= v;
        @(posedge core_clk_i);
        far_load <= 1'b1;
        @(posedge core_clk_i);
        far_load <= 1'b0;
    endtask
    task automatic wait_frame(input int n);
        int k;
        k = 0;
        while (far_frames != n && k < 4000) begin
            @(posedge core_clk_i);
            k++;
        end
        repeat (10) @(posedge core_clk_i);
        chk(8'(far_frames), 8'(n));
    endtask
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        #500000;
        n_fail++;
        give_verdict();
    end
    initial begin
        n_fail = 0;
        tests_run = 0;
        reset_i = 1'b1;
        wr_i = 1'b0;
        rd_i = 1'b0;
        ss_n_i = 1'b1;
        addr_i = 8'h00;
        wdata_i = 8'h00;
        far_tx = 8'h00;
        far_load = 1'b0;
        far_go = 1'b0;
        repeat (8) @(posedge core_clk_i);
        reset_i <= 1'b0;
        @(posedge core_clk_i);
        rd_chk(`SSR_OFF_CSR, 8'h00);
        rd_chk(`SSR_OFF_CTRL, 8'h00);
        rd_chk(8'h24, 8'h00);
        $display("test reset done");
        prep(8'h3C);
        wr(`SSR_OFF_CTRL, 8'hD3);
        wr(`SSR_OFF_DATA, 8'hA5);
        wait_frame(1);
        chk(far_rx, 8'hA5);
        pins_chk(2'b01);
        rd_chk(`SSR_OFF_CSR, 8'h80);
        rd_chk(`SSR_OFF_DATA, 8'h3C);
        rd_chk(`SSR_OFF_CSR, 8'h00);
        pins_chk(2'b00);
        $display("test master byte done");
        prep(8'h81);
        wr(`SSR_OFF_DATA, 8'hA5);
        wr(`SSR_OFF_DATA, 8'h11);
        wait_frame(2);
        wr(`SSR_OFF_DATA, 8'h55);
        rd_chk(`SSR_OFF_CSR, 8'hC0);
        chk(far_rx, 8'hA5);
        rd_chk(`SSR_OFF_DATA, 8'h81);
        rd_chk(`SSR_OFF_CSR, 8'h00);
        repeat (1200) @(posedge core_clk_i);
        chk(8'(far_frames), 8'h02);
        $display("test collision done");
        prep(8'h24);
        wr(`SSR_OFF_DATA, 8'h0F);
        wait_frame(3);
        rd_chk(`SSR_OFF_CSR, 8'h80);
        prep(8'h99);
        wr(`SSR_OFF_DATA, 8'hF0);
        wait_frame(4);
        chk(far_rx, 8'hF0);
        // status read then data write cleared done, so a master never overruns
        rd_chk(`SSR_OFF_CSR, 8'h80);
        rd_chk(`SSR_OFF_DATA, 8'h99);
        rd_chk(`SSR_OFF_CSR, 8'h00);
        $display("test second byte done");
        ss_n_i <= 1'b0;
        repeat (8) @(posedge core_clk_i);
        pins_chk(2'b01);
        rd_chk(`SSR_OFF_CSR, 8'h10);
        rd_chk(`SSR_OFF_CTRL, 8'h83);
        wr(`SSR_OFF_CTRL, 8'h83);
        rd_chk(`SSR_OFF_CSR, 8'h00);
        $display("test mode fault done");
        wr(`SSR_OFF_CSR, 8'h03);
        wr(`SSR_OFF_CTRL, 8'hD3);
        repeat (8) @(posedge core_clk_i);
        rd_chk(`SSR_OFF_CSR, 8'h03);
        wr(`SSR_OFF_CTRL, 8'hC0);
        wr(`SSR_OFF_CSR, 8'h06);
        pins_chk(2'b00);
        wr(`SSR_OFF_CSR, 8'h03);
        pins_chk(2'b00);
        wr(`SSR_OFF_CSR, 8'h02);
        pins_chk(2'b10);
        prep(8'h5A);
        wr(`SSR_OFF_DATA, 8'hC3);
        far_go <= 1'b1;
        wait_frame(5);
        rd_chk(`SSR_OFF_CSR, 8'h82);
        rd_chk(`SSR_OFF_DATA, 8'h5A);
        chk(far_rx, 8'hC3);
        $display("test slave byte done");
        // two slave bytes with no read between them: the second overruns
        far_go <= 1'b0;
        prep(8'h6B);
        far_go <= 1'b1;
        wait_frame(6);
        far_go <= 1'b0;
        prep(8'h2D);
        far_go <= 1'b1;
        wait_frame(7);
        rd_chk(`SSR_OFF_CSR, 8'hA2);
        rd_chk(`SSR_OFF_CSR, 8'h82);
        rd_chk(`SSR_OFF_DATA, 8'h6B);
        rd_chk(`SSR_OFF_CSR, 8'h02);
        $display("test overrun done");
        give_verdict();
    end
endmodule
`default_nettype wire

// ---- sim/ssr_far_end.sv ----
// far-side serial device: slave to the line clock, or master with an 80 ns clock
`timescale 1ns/1ns
`default_nettype none
module ssr_far_end (
    // line seen by this device
    input  wire logic       sck_in,
    input  wire logic       sdi,
    // byte to send
    input  wire logic [7:0] tx,
    input  wire logic       load,
    input  wire logic       go,
    // driven lines, results
    output logic            sck,
    output logic            sdo,
    output logic      [7:0] rx,
    output var int          frames
);
    logic [7:0] sh;
    int         n;
    initial begin
        sck = 1'b0;
        sh = 8'h00;
        rx = 8'h00;
        n = 0;
        frames = 0;
    end
    assign sdo = sh[7];
    always @(posedge load) begin
        sh = tx;
        n = 0;
    end
    // capture on leading edge, msb first
    always @(posedge sck_in) begin
        rx = {rx[6:0], sdi};
        n = n + 1;
    end
    // shift on trailing edge; vacated bits alternate so stale data never repeats
    always @(negedge sck_in) begin
        sh = {sh[6:0], ~sh[0]};
        if (n == 8) begin
            frames = frames + 1;
            n = 0;
        end
    end
    // clock stands low outside the frame; its edges keep off the block's clock edges
    always @(posedge go) begin
        #3;
        repeat (8) begin
            #40 sck = 1'b1;
            #40 sck = 1'b0;
        end
    end
endmodule
`default_nettype wire
